// *** core/tcs_timer.v ***
// Purpose: 8-bit overflow timer/counter with shared prescaler and apb registers
// Assumes: one instruction cycle is four pclk phases; pin inputs synchronous to pclk
// Notes: watchdog itself lives outside; this block drives its clear and takes its tick
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "tcs_regs.vh"

module tcs_timer (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // pins and system
  input  wire        ext_count_clock_pin,
  input  wire        wdog_tick,
  output reg         overflow_irq_ff,
  output reg         wdog_clear_ff,
  output reg         wdog_tick_out_ff
);

  // phase generator: phase 1 = second, phase 3 = fourth
  reg  [1:0] phase_ff;
  wire       cyc_end;
  wire       ph2;
  wire       ph4;
  assign cyc_end = (phase_ff == `TCS_PHASES);
  assign ph2     = (phase_ff == 2'd1);
  assign ph4     = (phase_ff == 2'd3);

  // registers
  reg  [7:0] timer_count_ff;
  reg  [7:0] cfg_ff;
  reg        overflow_flag_ff;
  reg        overflow_irq_mask_ff;
  reg        sleep_ff;
  reg  [1:0] hold_ff;
  reg        ext_prev_ff;
  reg        sync_a_ff;
  reg        sync_b_ff;
  reg        sync_prev_ff;
  reg        tap_prev_ff;

  wire       prescaler_assign_sel;
  wire [2:0] prescale_ratio_sel;
  wire       src_ext;
  wire       edge_fall;
  assign prescaler_assign_sel = cfg_ff[`TCS_CFG_ASSIGN_BIT];
  assign prescale_ratio_sel   = cfg_ff[`TCS_CFG_RATIO_HI:0];
  assign src_ext              = cfg_ff[`TCS_CFG_SRC_BIT];
  assign edge_fall            = cfg_ff[`TCS_CFG_EDGE_BIT];

  // apb decode
  wire       acc;
  wire       wr;
  wire [9:0] idx;
  wire       hit_cnt;
  wire       hit_ic;
  wire       hit_cfg;
  wire       hit_sc;
  wire       hit_ws;
  wire       mapped;
  assign acc     = psel & penable & ~pready;
  assign wr      = acc & pwrite;
  assign idx     = paddr[11:2];
  assign hit_cnt = (idx == {2'b00, `TCS_IDX_TIMER_COUNT});
  assign hit_ic  = (idx == {2'b00, `TCS_IDX_INTR_CTRL});
  assign hit_cfg = (idx == {2'b00, `TCS_IDX_TIMER_CFG});
  assign hit_sc  = (idx == {2'b00, `TCS_IDX_SYS_CTRL});
  assign hit_ws  = (idx == {2'b00, `TCS_IDX_WDOG_STAT});
  assign mapped  = hit_cnt | hit_ic | hit_cfg | hit_sc | hit_ws;

  wire wr_cnt;
  wire wdclr;
  assign wr_cnt = wr & hit_cnt;
  assign wdclr  = wr & hit_sc & pwdata[`TCS_SC_WDCLR_BIT];

  // external edge detect on selected polarity
  wire ext_edge;
  assign ext_edge = edge_fall ? (ext_prev_ff & ~ext_count_clock_pin)
                              : (~ext_prev_ff & ext_count_clock_pin);

  // prescaler source: watchdog tick when watchdog-assigned, else timer source
  wire pre_adv;
  wire pre_clr;
  wire tap;
  assign pre_adv = prescaler_assign_sel ? wdog_tick
                 : (src_ext ? ext_edge : (cyc_end & ~sleep_ff));
  assign pre_clr = (~prescaler_assign_sel & wr_cnt) | (prescaler_assign_sel & wdclr);

  tcs_prescale u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (pre_clr),
    .adv     (pre_adv),
    .ratio   (prescale_ratio_sel),
    .tap     (tap)
  );

  // prescaled tick: rising tap edge, divider runs ahead of sync
  wire tap_rise;
  assign tap_rise = tap & ~tap_prev_ff;

  // external path signal presented to the synchroniser
  wire ext_src_lvl;
  assign ext_src_lvl = prescaler_assign_sel ? (edge_fall ? ~ext_count_clock_pin : ext_count_clock_pin)
                                            : tap;

  // synchronised external rise
  wire sync_rise;
  assign sync_rise = sync_b_ff & ~sync_prev_ff;

  // count enable selection
  reg inc;
  always @* begin
    inc = 1'b0;
    if (src_ext)
      inc = sync_rise & cyc_end;
    else if (prescaler_assign_sel)
      inc = cyc_end;
    else
      inc = tap_rise;
  end

  wire count_go;
  assign count_go = inc & ~sleep_ff & (hold_ff == 2'd0);

  // latch of pending synchronised edge until cycle end
  reg sync_pend_ff;
  wire sync_hit;
  assign sync_hit = sync_rise | sync_pend_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff         <= 2'd0;
      timer_count_ff   <= `TCS_CNT_RESET;
      cfg_ff           <= `TCS_CFG_RESET;
      overflow_flag_ff <= 1'b0;
      overflow_irq_mask_ff <= 1'b0;
      sleep_ff         <= 1'b0;
      hold_ff          <= 2'd0;
      ext_prev_ff      <= 1'b0;
      sync_a_ff        <= 1'b0;
      sync_b_ff        <= 1'b0;
      sync_prev_ff     <= 1'b0;
      sync_pend_ff     <= 1'b0;
      tap_prev_ff      <= 1'b0;
      overflow_irq_ff  <= 1'b0;
      wdog_clear_ff    <= 1'b0;
      wdog_tick_out_ff <= 1'b0;
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
    end else begin
      phase_ff    <= phase_ff + 2'd1;
      ext_prev_ff <= ext_count_clock_pin;
      tap_prev_ff <= tap;
      // two-stage sample on second then fourth phase
      if (ph2)
        sync_a_ff <= ext_src_lvl;
      if (ph4)
        sync_b_ff <= sync_a_ff;
      sync_prev_ff <= sync_b_ff;
      if (sync_rise & ~cyc_end)
        sync_pend_ff <= 1'b1;
      else if (cyc_end)
        sync_pend_ff <= 1'b0;

      // hold-off after a write counts instruction cycles
      if (wr_cnt)
        hold_ff <= `TCS_WR_HOLD_CYC;
      else if (cyc_end && hold_ff != 2'd0)
        hold_ff <= hold_ff - 2'd1;

      // counter and overflow
      if (wr_cnt)
        timer_count_ff <= pwdata[7:0];
      else if ((src_ext ? (sync_hit & cyc_end) : inc) && !sleep_ff && hold_ff == 2'd0) begin
        timer_count_ff <= timer_count_ff + 8'h01;
      end

      // set wins over software clear
      if (!wr_cnt && count_go | (src_ext & sync_hit & cyc_end & ~sleep_ff & hold_ff == 2'd0)
          && timer_count_ff == 8'hff)
        overflow_flag_ff <= 1'b1;
      else if (wr & hit_ic)
        overflow_flag_ff <= pwdata[`TCS_IC_FLAG_BIT];

      if (wr & hit_ic)
        overflow_irq_mask_ff <= pwdata[`TCS_IC_MASK_BIT];
      if (wr & hit_cfg)
        cfg_ff <= pwdata[7:0];
      if (wr & hit_sc)
        sleep_ff <= pwdata[`TCS_SC_SLEEP_BIT];

      overflow_irq_ff  <= overflow_flag_ff & overflow_irq_mask_ff & ~sleep_ff;
      wdog_clear_ff    <= wdclr;
      // watchdog sees prescaled tick or raw tick
      wdog_tick_out_ff <= prescaler_assign_sel ? tap_rise : wdog_tick;

      // apb: one wait state, answer on second access cycle
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc & ~pwrite) begin
        case (1'b1)
          hit_cnt: prdata <= {24'h000000, timer_count_ff};
          hit_ic:  prdata <= {26'h0000000, overflow_irq_mask_ff, 2'b00, overflow_flag_ff, 2'b00};
          hit_cfg: prdata <= {24'h000000, cfg_ff};
          hit_sc:  prdata <= {31'h00000000, sleep_ff};
          hit_ws:  prdata <= {29'h00000000, overflow_irq_ff, hold_ff};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (acc)
        prdata <= 32'h0000_0000;
    end
  end

endmodule // tcs_timer

// *** pkg/tcs_regs.vh ***
// Purpose: register map, field positions, reset values and timing counts of the shared-prescaler timer
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: printed offsets not all multiples of four, so they are indices
`ifndef TCS_REGS_VH
`define TCS_REGS_VH

// register indices as printed, byte address is four times the index
`define TCS_IDX_TIMER_COUNT   8'h01
`define TCS_IDX_INTR_CTRL     8'h0b
`define TCS_IDX_TIMER_CFG     8'h81
// own register: sleep request, watchdog clear strobe, status
`define TCS_IDX_SYS_CTRL      8'h90
`define TCS_IDX_WDOG_STAT     8'h91

// interrupt control fields
`define TCS_IC_MASK_BIT       5
`define TCS_IC_FLAG_BIT       2
// timer configuration fields
`define TCS_CFG_SRC_BIT       5
`define TCS_CFG_EDGE_BIT      4
`define TCS_CFG_ASSIGN_BIT    3
`define TCS_CFG_RATIO_HI      2
// system control fields
`define TCS_SC_SLEEP_BIT      0
`define TCS_SC_WDCLR_BIT      1

// reset values
`define TCS_CFG_RESET         8'hff
`define TCS_IC_RESET          8'h00
`define TCS_CNT_RESET         8'h00

// write hold-off in instruction cycles
`define TCS_WR_HOLD_CYC       2'd2
// last phase index of an instruction cycle (four phase clocks, 0 to 3)
`define TCS_PHASES            2'd3

`endif

// *** core/tcs_prescale.v ***
// Purpose: single 8-bit prescale counter shared by timer and watchdog
// Assumes: clear and advance are one-cycle pulses on pclk
// Notes: no software access path to the count
`timescale 1ns/1ps
`include "tcs_regs.vh"

module tcs_prescale (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // control
  input  wire       clr,
  input  wire       adv,
  input  wire [2:0] ratio,
  // output
  output wire       tap
);

  reg  [7:0] pre_ff;
  wire [7:0] nxt_pre;

  // one counter only, cleared on request
  assign nxt_pre = clr ? 8'h00 : (adv ? pre_ff + 8'h01 : pre_ff);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_ff <= 8'h00;
    else
      pre_ff <= nxt_pre;
  end

  // ratio 000 selects bit 0 (1:2) up to bit 7 (1:256)
  assign tap = pre_ff[ratio];

endmodule // tcs_prescale

// *** bench/tcs_ext_src.sv ***
// Purpose: far-side source of count pin pulses and watchdog ticks
// Assumes: pin levels synchronous to pclk
// Notes: pin rests low between bursts
`timescale 1ns/1ps
module tcs_ext_src (
  // clock
  input  logic pclk,
  // lines toward the timer
  output logic pin,
  output logic tick
);
  initial begin
    pin = 1'b0;
    tick = 1'b0;
  end
  // each level held four clocks, above the two-period minimum
  task pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      pin <= 1'b1;
      repeat (4) @(posedge pclk);
      pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule // tcs_ext_src

// *** bench/tcs_timer_asserts.sv ***
// Purpose: port checks of the timer block
// Assumes: apb answer after one wait state
// Notes: bound from the bench top
`timescale 1ns/1ps
module tcs_timer_asserts (
  // apb
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // system
  input logic        wdog_clear_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire take = psel & penable & !pready;
  wire wdclr = take & pwrite & (paddr == 12'h240) & pwdata[1];
  one_wait_a: assert property (take |=> pready) else $error("no answer after one wait");
  ready_cause_a: assert property (pready |-> $past(take)) else $error("answer without request");
  ready_pulse_a: assert property (pready |=> !pready) else $error("answer held");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without answer");
  unmapped_zero_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("refused read data");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  count_mapped_a: assert property (take && paddr == 12'h004 |=> !pslverr) else $error("count refused");
  wd_clear_a: assert property (wdclr |-> ##[1:2] wdog_clear_ff) else $error("no watchdog clear");
  wd_pulse_a: assert property (wdog_clear_ff |=> !wdog_clear_ff) else $error("clear held");
endmodule // tcs_timer_asserts

// *** bench/tcs_timer_tb_top.sv ***
// Purpose: self-checking bench of the timer block
// Assumes: read data latched on the same edge as pready
// Notes: rate checks rely on fixed apb spacing
`timescale 1ns/1ps
module tcs_timer_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pin, wtick, pready, pslverr, irq, wclr, wout, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r0, r1;
  int          num_errors, samples_checked, nclr, nout, a;
  logic [7:0]  cf [5] = '{8'h08, 8'h00, 8'h01, 8'h02, 8'h07};
  int          per [5] = '{4, 8, 16, 32, 1024};
  tcs_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clock_pin(pin), .wdog_tick(wtick), .overflow_irq_ff(irq), .wdog_clear_ff(wclr),
    .wdog_tick_out_ff(wout));
  tcs_ext_src u_src (.pclk(pclk), .pin(pin), .tick(wtick));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    nclr <= nclr + wclr;
    nout <= nout + wout;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog process ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, r1);
  endtask
  task t_reset;
    xfer(1'b0, 12'h204, 0, r0); chk(r0, 32'hff);
    xfer(1'b0, 12'h02c, 0, r0); chk(r0, 32'h0);
    xfer(1'b0, 12'h100, 0, r0); chk({err, r0[30:0]}, 32'h80000000);
    $display("reset test done");
  endtask
  // gap of ten periods between the two sampling edges
  task t_rate;
    for (int i = 0; i < 5; i++) begin
      wr(12'h204, cf[i]);
      wr(12'h004, 32'h10);
      xfer(1'b0, 12'h004, 0, r0); chk(r0, 32'h10);
      // baseline taken once the write hold-off has run out
      repeat (8) @(posedge pclk);
      xfer(1'b0, 12'h004, 0, r0);
      repeat (10 * per[i] - 4) @(posedge pclk);
      xfer(1'b0, 12'h004, 0, r1); chk(r1 - r0, 32'd10);
    end
    $display("rate test done");
  endtask
  task t_ovf;
    wr(12'h204, 8'h08);
    wr(12'h02c, 0);
    wr(12'h004, 8'hfe);
    repeat (20) @(posedge pclk);
    xfer(1'b0, 12'h02c, 0, r0); chk(r0, 32'h04);
    chk(irq, 1'b0);
    wr(12'h02c, 8'h24);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(12'h02c, 8'h20);
    repeat (2) @(posedge pclk);
    xfer(1'b0, 12'h02c, 0, r0); chk({irq, r0[30:0]}, 32'h20);
    $display("overflow test done");
  endtask
  task t_sleep;
    wr(12'h240, 1);
    xfer(1'b0, 12'h004, 0, r0);
    repeat (36) @(posedge pclk);
    xfer(1'b0, 12'h004, 0, r1); chk(r1, r0);
    wr(12'h240, 0);
    $display("sleep test done");
  endtask
  task t_wdog;
    wr(12'h240, 2);
    wr(12'h204, 8'h00);
    a = nout;
    u_src.ticks(8);
    repeat (3) @(posedge pclk);
    chk(nout - a, 8);
    wr(12'h240, 2);
    wr(12'h004, 0);
    wr(12'h204, 8'h0d);
    wr(12'h240, 2);
    wr(12'h204, 8'h08);
    a = nclr;
    wr(12'h240, 2);
    repeat (2) @(posedge pclk);
    chk(nclr - a, 1);
    a = nout;
    u_src.ticks(16);
    repeat (3) @(posedge pclk);
    chk(nout - a, 8);
    $display("watchdog test done");
  endtask
  task t_ext;
    for (int e = 0; e < 2; e++) begin
      wr(12'h204, e ? 8'h38 : 8'h28);
      // let a level flip from the polarity change pass the synchroniser
      repeat (16) @(posedge pclk);
      xfer(1'b0, 12'h004, 0, r0);
      u_src.pulses(10);
      repeat (12) @(posedge pclk);
      xfer(1'b0, 12'h004, 0, r1); chk(r1 - r0, 32'd10);
    end
    $display("external test done");
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_rate;
    t_ovf;
    t_sleep;
    t_wdog;
    t_ext;
    results;
  end
  initial begin
    #200000;
    num_errors++;
    results;
  end
endmodule // tcs_timer_tb_top
bind tcs_timer tcs_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wdog_clear_ff(wdog_clear_ff));
